// *** rtl/dfr_pkg.sv ***
// Shared constants of the drive fault relay and reference loss block.
// Assumes one 10 MHz system clock and an AXI4-Lite register master.
package dfr_pkg;
   // Clock and loss timer unit (0.1 s per wait-time step)
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned LOSS_UNIT_US = 100_000;
   localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * LOSS_UNIT_US;
   localparam int TICK_W = 24;

   // Register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_WAIT = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;

   // Control register field positions
   localparam int SEL_LSB = 0;
   localparam int REN_LSB = 8;
   localparam int ACT_LSB = 16;

   // Values after reset
   localparam logic [4:0] SEL_RESET = 5'h00;
   localparam logic [2:0] REN_RESET = 3'h0;
   localparam logic [1:0] ACT_RESET = 2'h0;
   localparam logic [7:0] WAIT_RESET = 8'h0a;

   // Status output condition codes
   localparam logic [4:0] SEL_STEADY = 5'h0e;
   localparam logic [4:0] SEL_SEARCH = 5'h11;
   localparam logic [4:0] SEL_READY = 5'h14;

   // Relay enable bits
   localparam int REN_UV = 0;
   localparam int REN_TRIP = 1;
   localparam int REN_RETRY = 2;

   // Loss action codes
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_COAST = 2'h1;
   localparam logic [1:0] ACT_STOP = 2'h2;

   // Frequency sources that count as keypad references
   localparam logic [2:0] SRC_KEYPAD1 = 3'h0;
   localparam logic [2:0] SRC_KEYPAD2 = 3'h1;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/dfr_loss_timer.sv ***
// Reference loss timer: counts whole wait-time steps while no valid
// reference is present. Inputs are synchronous to sys_clk.
`timescale 1ns/100ps
module dfr_loss_timer import dfr_pkg::*; #(
   parameter logic [TICK_W-1:0] TICK_LEN = TICK_W'(TICK_CYCLES)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Reference state
   input wire logic ref_missing,
   input wire logic [7:0] wait_time,
   // Result
   output logic ref_loss,
   output logic [7:0] elapsed
);
   typedef struct packed {
      logic [TICK_W-1:0] div;
      logic [7:0] steps;
      logic loss;
   } dfr_lt_t;

   dfr_lt_t st_reg, st_next;

   // Divider restarts with the step count, so a loss never comes early
   always_comb begin
      st_next = st_reg;
      if (!ref_missing) begin
         st_next.div = '0;
         st_next.steps = 8'h00;
         st_next.loss = 1'b0;
      end else begin
         if (st_reg.steps < wait_time) begin
            if (st_reg.div == TICK_LEN - 1'b1) begin
               st_next.div = '0;
               st_next.steps = st_reg.steps + 8'h01;
            end else begin
               st_next.div = st_reg.div + 1'b1;
            end
         end
         st_next.loss = (st_next.steps >= wait_time);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ref_loss = st_reg.loss;
   assign elapsed = st_reg.steps;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_loss_clears: assert property (!ref_missing |=> !ref_loss)
      else $error("loss flag not cleared by valid reference");
   a_loss_waits: assert property ($rose(ref_loss) |-> elapsed >= wait_time)
      else $error("loss declared before wait time");
   a_timer_restart: assert property (!ref_missing |=> elapsed == 8'h00)
      else $error("wait timer not restarted");
   c_loss_seen: cover property ($rose(ref_loss));
endmodule // dfr_loss_timer

// *** rtl/dfr_top.sv ***
// Drive supervisory block: status output, fault relay, reference loss.
// Assumes fault and status flags synchronous to sys_clk and an
// AXI4-Lite master that keeps one read and one write in flight.
`timescale 1ns/100ps
// Contract
// - Selector 14 closes status output while drive holds steady speed.
// - Selector 17 closes status output throughout a speed search.
// - Selector 20 closes status output while drive is ready to run.
// - One relay: activation closes open contact, opens closed contact.
// - Enable bit 0 lets undervoltage trip activate the relay.
// - Enable bit 1 lets all faults except undervoltage, disable input act.
// - Enable bit 2 activates relay only when retry count reaches zero.
// - Simultaneous faults: undervoltage enable bit decides first.
// - Keypad sources: loss on communication failure for the wait time.
// - Other sources: loss judged by the analog loss criterion.
// - Loss only after full wait without reference; timer restarts.
// - Action 0 keeps running at the frequency held before loss.
// - Action 1 removes output at once so the motor coasts.
// - Action 2 ramps to stop with configured decel time and pattern.
// - Loss action resets to 0, no action.
// - Wait time resets to 10, one second.
// - Status output closed while its condition holds, else open.
// - Codes 14, 17, 20 used; 15, 16, 18, 19 reserved.
module dfr_top import dfr_pkg::*; #(
   parameter logic [TICK_W-1:0] TICK_LEN = TICK_W'(TICK_CYCLES)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // AXI4-Lite write
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Drive status
   input wire logic steady_speed,
   input wire logic speed_searching,
   input wire logic drive_ready,
   // Fault flags
   input wire logic undervoltage_trip,
   input wire logic inverter_disable_input,
   input wire logic other_fault,
   input wire logic [7:0] retry_count_setting,
   // Frequency reference
   input wire logic [2:0] frequency_source_select,
   input wire logic comm_error,
   input wire logic analog_loss,
   input wire logic [15:0] freq_ref_in,
   input wire logic [15:0] decel_time,
   input wire logic [1:0] decel_pattern,
   // Plant outputs
   output logic status_output,
   output logic relay_open_contact,
   output logic relay_closed_contact,
   output logic [15:0] freq_cmd,
   output logic coast_stop,
   output logic ramp_stop,
   output logic [15:0] stop_decel_time,
   output logic [1:0] stop_decel_pattern,
   output logic ref_loss
);
   typedef struct packed {
      logic aw_have;
      logic [3:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [4:0] sel;
      logic [2:0] ren;
      logic [1:0] act;
      logic [7:0] wait_t;
      logic status;
      logic relay;
      logic relay_n;
      logic [15:0] freq_hold;
      logic [15:0] freq;
      logic coast;
      logic ramp;
      logic [15:0] dtime;
      logic [1:0] dpat;
   } dfr_st_t;

   dfr_st_t st_reg, st_next;
   logic loss;
   logic [7:0] elapsed;
   logic missing;
   logic keypad_src;

   // Byte-lane merge used by both writable registers
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Status output condition per selector code
   function automatic logic cond(input logic [4:0] sel,
                                 input logic stdy,
                                 input logic srch,
                                 input logic rdy);
      case (sel)
         SEL_STEADY: cond = stdy;
         SEL_SEARCH: cond = srch;
         SEL_READY: cond = rdy;
         default: cond = 1'b0;
      endcase
   endfunction

   assign keypad_src = (frequency_source_select == SRC_KEYPAD1) ||
                       (frequency_source_select == SRC_KEYPAD2);
   assign missing = keypad_src ? comm_error : analog_loss;

   dfr_loss_timer #(
      .TICK_LEN(TICK_LEN)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ref_missing(missing),
      .wait_time(st_reg.wait_t),
      .ref_loss(loss),
      .elapsed(elapsed)
   );

   logic any_fault;
   logic relay_calc;
   logic [31:0] ctrl_word;
   logic [31:0] ctrl_new;
   logic [31:0] wait_new;
   logic [31:0] stat_word;

   assign any_fault = undervoltage_trip | inverter_disable_input |
                      other_fault;
   assign ctrl_word = {14'h0000, st_reg.act, 5'h00, st_reg.ren,
                       3'h0, st_reg.sel};
   assign ctrl_new = merge(ctrl_word, st_reg.w_data, st_reg.w_strb);
   assign wait_new = merge({24'h000000, st_reg.wait_t}, st_reg.w_data,
                           st_reg.w_strb);
   assign stat_word = {16'h0000, elapsed, 2'h0, st_reg.ramp,
                       st_reg.coast, loss, st_reg.relay, 1'b0,
                       st_reg.status};

   // Undervoltage present: its enable alone decides, whatever else trips
   always_comb begin
      if (undervoltage_trip) begin
         relay_calc = st_reg.ren[REN_UV];
      end else begin
         relay_calc = (st_reg.ren[REN_TRIP] & other_fault) |
                      (st_reg.ren[REN_RETRY] & any_fault &
                       (retry_count_setting == 8'h00));
      end
   end

   always_comb begin
      st_next = st_reg;
      // Write address and data in either order
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
         st_next.awready = 1'b0;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_have = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
         st_next.wready = 1'b0;
      end
      if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         case (st_reg.aw_addr)
            ADDR_CTRL: begin
               st_next.sel = ctrl_new[SEL_LSB +: 5];
               st_next.ren = ctrl_new[REN_LSB +: 3];
               st_next.act = ctrl_new[ACT_LSB +: 2];
            end
            ADDR_WAIT: begin
               st_next.wait_t = wait_new[7:0];
            end
            ADDR_STATUS: begin
               st_next.bresp = RESP_OKAY;
            end
            default: begin
               st_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.awready = 1'b1;
         st_next.wready = 1'b1;
      end
      // Read: one cycle from address to data
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.arready = 1'b0;
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CTRL: st_next.rdata = ctrl_word;
            ADDR_WAIT: st_next.rdata = {24'h000000, st_reg.wait_t};
            ADDR_STATUS: st_next.rdata = stat_word;
            default: begin
               st_next.rdata = 32'h00000000;
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
         st_next.arready = 1'b1;
      end
      // Plant side
      st_next.status = cond(st_reg.sel, steady_speed, speed_searching,
                            drive_ready);
      st_next.relay = relay_calc;
      st_next.relay_n = ~relay_calc;
      if (!loss) begin
         st_next.freq_hold = freq_ref_in;
      end
      st_next.coast = 1'b0;
      st_next.ramp = 1'b0;
      st_next.freq = freq_ref_in;
      st_next.dtime = decel_time;
      st_next.dpat = decel_pattern;
      if (loss) begin
         case (st_reg.act)
            ACT_COAST: st_next.coast = 1'b1;
            ACT_STOP: st_next.ramp = 1'b1;
            default: st_next.freq = st_reg.freq_hold;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.awready <= 1'b1;
         st_reg.wready <= 1'b1;
         st_reg.arready <= 1'b1;
         st_reg.relay_n <= 1'b1;
         st_reg.sel <= SEL_RESET;
         st_reg.ren <= REN_RESET;
         st_reg.act <= ACT_RESET;
         st_reg.wait_t <= WAIT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign status_output = st_reg.status;
   // Two flops loaded from one decision, so the contacts never overlap
   assign relay_open_contact = st_reg.relay;
   assign relay_closed_contact = st_reg.relay_n;
   assign freq_cmd = st_reg.freq;
   assign coast_stop = st_reg.coast;
   assign ramp_stop = st_reg.ramp;
   assign stop_decel_time = st_reg.dtime;
   assign stop_decel_pattern = st_reg.dpat;
   assign ref_loss = loss;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_status_steady: assert property (st_reg.sel == SEL_STEADY &&
      $stable(st_reg.sel) |=> status_output == $past(steady_speed))
      else $error("status output does not follow steady speed");
   a_status_search: assert property (st_reg.sel == SEL_SEARCH &&
      $stable(st_reg.sel) |=> status_output == $past(speed_searching))
      else $error("status output does not follow speed search");
   a_status_ready: assert property (st_reg.sel == SEL_READY &&
      $stable(st_reg.sel) |=> status_output == $past(drive_ready))
      else $error("status output does not follow ready");
   a_status_reserved: assert property (st_reg.sel inside {5'h0f, 5'h10,
      5'h12, 5'h13} && $stable(st_reg.sel) |=> !status_output)
      else $error("reserved selector closed status output");
   a_contacts_opposed: assert property (relay_open_contact !=
      relay_closed_contact)
      else $error("relay contacts not complementary");
   a_uv_priority: assert property (undervoltage_trip && $stable(st_reg.ren)
      |=> relay_open_contact == $past(st_reg.ren[REN_UV]))
      else $error("undervoltage enable did not decide relay");
   a_disable_only: assert property (inverter_disable_input &&
      !undervoltage_trip && !other_fault && retry_count_setting != 8'h00
      |=> !relay_open_contact)
      else $error("disable input alone activated relay");
   a_retry_zero: assert property (!undervoltage_trip && !other_fault &&
      inverter_disable_input && st_reg.ren[REN_RETRY] &&
      $stable(st_reg.ren) && retry_count_setting == 8'h00
      |=> relay_open_contact)
      else $error("exhausted retry count did not activate relay");
   a_coast_action: assert property (loss && st_reg.act == ACT_COAST &&
      $stable(st_reg.act) |=> coast_stop && !ramp_stop)
      else $error("coast action not taken on loss");
   a_stop_action: assert property (loss && st_reg.act == ACT_STOP &&
      $stable(st_reg.act) |=> ramp_stop && !coast_stop)
      else $error("ramp stop not taken on loss");
   a_hold_freq: assert property (loss && $past(loss) &&
      st_reg.act == ACT_NONE |=> $stable(freq_cmd))
      else $error("frequency not held on loss");

   c_relay_on: cover property ($rose(relay_open_contact));
   c_coast: cover property ($rose(coast_stop));
   c_write_done: cover property (s_axi_bvalid && s_axi_bready);
   c_status_ready: cover property (st_reg.sel == SEL_READY &&
      status_output);
endmodule // dfr_top

// *** bench/dfr_plant_model.sv ***
// Plant side of the drive outputs: lamp, permit wiring and a contact monitor.
// Assumes relay contacts are sampled on sys_clk; the status output drives its lamp directly.
`timescale 1ns/100ps
module dfr_plant_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Drive outputs
   input wire logic status_output,
   input wire logic relay_open_contact,
   input wire logic relay_closed_contact,
   // Plant view
   output logic status_lamp,
   output logic alarm_lamp,
   output logic run_permit,
   output logic contact_clash
);
   assign status_lamp = status_output;
   assign alarm_lamp = relay_open_contact;
   assign run_permit = relay_closed_contact;
   // Both paths share one common, so both closed or both open is a fault
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         contact_clash <= 1'b0;
      end else if (relay_open_contact === relay_closed_contact) begin
         contact_clash <= 1'b1;
      end
   end
endmodule // dfr_plant_model

// *** bench/drive_fault_relay_ref_loss_test.sv ***
// Self-checking bench for dfr_top with the plant model on its outputs.
// Assumes TICK_LEN is cut to 4 cycles so one wait step is short.
`timescale 1ns/100ps
module drive_fault_relay_ref_loss_test import dfr_pkg::*;;
   localparam int TICK = 4;
   localparam int STEPS = 3;
   logic sys_clk, rst_n;
   logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic steady_speed, speed_searching, drive_ready, undervoltage_trip;
   logic inverter_disable_input, other_fault, comm_error, analog_loss;
   logic [7:0] retry_count_setting;
   logic [2:0] frequency_source_select;
   logic [15:0] freq_ref_in, decel_time, freq_cmd, stop_decel_time;
   logic [1:0] decel_pattern, stop_decel_pattern;
   logic status_output, relay_open_contact, relay_closed_contact;
   logic coast_stop, ramp_stop, ref_loss;
   logic status_lamp, alarm_lamp, run_permit, contact_clash;
   int n_errors = 0;
   int samples_checked = 0;
   logic [4:0] codes [5] = '{SEL_STEADY, SEL_SEARCH, SEL_READY, 5'h0f, 5'h12};
   // ren[7:5] uv bx other retry_zero expected
   logic [7:0] rtab [10] = '{8'h31, 8'h10, 8'h45, 8'h48, 8'h06, 8'h87,
                             8'h84, 8'h8b, 8'hd4, 8'h75};

   dfr_top #(.TICK_LEN(24'h000004)) i_dfr_top (.sys_clk, .rst_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .steady_speed, .speed_searching, .drive_ready,
      .undervoltage_trip, .inverter_disable_input, .other_fault,
      .retry_count_setting, .frequency_source_select, .comm_error,
      .analog_loss, .freq_ref_in, .decel_time, .decel_pattern,
      .status_output, .relay_open_contact, .relay_closed_contact,
      .freq_cmd, .coast_stop, .ramp_stop, .stop_decel_time,
      .stop_decel_pattern, .ref_loss);

   dfr_plant_model i_dfr_plant_model (.sys_clk, .rst_n, .status_output,
      .relay_open_contact, .relay_closed_contact, .status_lamp,
      .alarm_lamp, .run_permit, .contact_clash);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic test_done();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Waits on the slave's answer with no assumed latency
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic set_miss(input logic kp, input logic rel, input logic irr);
      comm_error <= kp ? rel : irr;
      analog_loss <= kp ? irr : rel;
   endtask

   task automatic loss_case(input logic [2:0] src, input logic [1:0] act);
      logic kp;
      kp = (src == SRC_KEYPAD1) || (src == SRC_KEYPAD2);
      axi_wr(ADDR_CTRL, {14'h0, act, 16'h0000}, rsp);
      @(posedge sys_clk);
      frequency_source_select <= src;
      freq_ref_in <= 16'h1234;
      set_miss(kp, 1'b0, 1'b1);
      repeat (20) @(posedge sys_clk);
      #1 chk("ref_loss_wrong_source", 32'h0, ref_loss);
      @(posedge sys_clk);
      set_miss(kp, 1'b1, 1'b1);
      repeat (8) @(posedge sys_clk);
      set_miss(kp, 1'b0, 1'b1);
      @(posedge sys_clk);
      set_miss(kp, 1'b1, 1'b1);
      repeat (STEPS * TICK - 1) @(posedge sys_clk);
      #1 chk("ref_loss_early", 32'h0, ref_loss);
      @(posedge sys_clk);
      #1 chk("ref_loss_set", 32'h1, ref_loss);
      @(posedge sys_clk);
      freq_ref_in <= 16'h5a5a;
      @(posedge sys_clk);
      #1 chk("coast", {31'h0, act == ACT_COAST}, coast_stop);
      chk("ramp", {31'h0, act == ACT_STOP}, ramp_stop);
      chk("freq_cmd", (act == ACT_NONE) ? 32'h1234 : 32'h5a5a,
          freq_cmd);
      chk("decel_time", 32'h0258, stop_decel_time);
      chk("decel_pattern", 32'h1, stop_decel_pattern);
      axi_rd(ADDR_STATUS, rd, rsp);
      chk("status_loss", {26'h0, act == ACT_STOP, act == ACT_COAST, 4'h8},
          rd[5:0] & 32'h38);
      @(posedge sys_clk);
      set_miss(kp, 1'b0, 1'b0);
      @(posedge sys_clk);
      #1 chk("ref_loss_clear", 32'h0, ref_loss);
      @(posedge sys_clk);
      #1 chk("stop_clear", 32'h0, {coast_stop, ramp_stop});
      axi_rd(ADDR_STATUS, rd, rsp);
      chk("elapsed_clear", 32'h0, rd[15:8]);
   endtask

   initial begin
      repeat (6000) @(posedge sys_clk);
      n_errors++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      {steady_speed, speed_searching, drive_ready} = '0;
      {undervoltage_trip, inverter_disable_input, other_fault} = '0;
      {comm_error, analog_loss} = '0;
      retry_count_setting = 8'h03;
      frequency_source_select = SRC_KEYPAD1;
      freq_ref_in = 16'h0000;
      decel_time = 16'h0258;
      decel_pattern = 2'h1;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      #1 chk("relay_reset", 32'h1, {relay_open_contact,
                                     relay_closed_contact});
      axi_rd(ADDR_CTRL, rd, rsp);
      chk("ctrl_reset", 32'h0, rd);
      axi_rd(ADDR_WAIT, rd, rsp);
      chk("wait_reset", 32'h0a, rd[7:0]);
      axi_rd(4'hc, rd, rsp);
      chk("unmapped_resp", RESP_SLVERR, rsp);
      axi_wr(ADDR_STATUS, 32'hffff_ffff, rsp);
      chk("status_wr_resp", RESP_OKAY, rsp);
      axi_wr(ADDR_WAIT, STEPS, rsp);
      // Lane 0 masked off, so the wait time must survive this write
      s_axi_wstrb <= 4'he;
      axi_wr(ADDR_WAIT, 32'h0000_00ff, rsp);
      s_axi_wstrb <= 4'hf;
      axi_rd(ADDR_WAIT, rd, rsp);
      chk("wait_strobe", STEPS, rd);
      foreach (codes[c]) begin
         axi_wr(ADDR_CTRL, {27'h0, codes[c]}, rsp);
         for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            {drive_ready, speed_searching, steady_speed} <= 3'b001 << i;
            @(posedge sys_clk);
            @(posedge sys_clk);
            #1 chk("status_output", {31'h0, (codes[c] == SEL_STEADY && i == 0)
               || (codes[c] == SEL_SEARCH && i == 1)
               || (codes[c] == SEL_READY && i == 2)},
               status_output);
         end
      end
      foreach (rtab[k]) begin
         axi_wr(ADDR_CTRL, {21'h0, rtab[k][7:5], 8'h00}, rsp);
         @(posedge sys_clk);
         undervoltage_trip <= rtab[k][4];
         inverter_disable_input <= rtab[k][3];
         other_fault <= rtab[k][2];
         retry_count_setting <= rtab[k][1] ? 8'h00 : 8'h03;
         @(posedge sys_clk);
         @(posedge sys_clk);
         #1 chk("relay", {30'h0, rtab[k][0], !rtab[k][0]},
            {relay_open_contact, relay_closed_contact});
         chk("lamps", {30'h0, rtab[k][0], !rtab[k][0]},
            {alarm_lamp, run_permit});
      end
      @(posedge sys_clk);
      {undervoltage_trip, inverter_disable_input, other_fault} <= '0;
      loss_case(SRC_KEYPAD1, ACT_NONE);
      loss_case(SRC_KEYPAD2, ACT_COAST);
      loss_case(3'h4, ACT_STOP);
      chk("contact_clash", 32'h0, contact_clash);
      test_done();
   end
endmodule // drive_fault_relay_ref_loss_test
